// ### hdl/obc_config_loader.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - Four option bytes, three user, one debug
// - Load bytes automatically after every reset release
// - Interval interrupt at 75% when bit set
// - Window code 01=50%, 10=75%, 11=100%
// - Run-enable bit starts watchdog after reset
// - Overflow code selects 2^6..2^16 low-speed cycles
// - Standby-run bit keeps watchdog counting in standby
// - Standby-run zero forces 100% window
// - Mode 10: interrupt-and-reset, grouped thresholds
// - Mode 11: reset-only, twelve thresholds
// - Mode 01: interrupt-only, twelve thresholds
// - Group top and mode low bits switch detector off
// - Third byte picks oscillator and flash mode
// - Debug byte enables debug and erase choice
// - Pin select: 0 port, 1 reset input
// - Flash code 10 low speed, 11 high speed
// - Nine oscillator codes, others prohibited
// - Debug bits 00 off, 10 erase, 11 keep
module obc_config_loader (
    input wire logic aclk,
    input wire logic aresetn,
    output logic [19:0] nvm_addr,
    output logic nvm_rd,
    input wire logic [7:0] nvm_data,
    output obc_pkg::obc_wdt_t wdt_cfg_ff,
    output obc_pkg::obc_sys_t sys_cfg_ff,
    output logic cfg_valid_ff,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [3:0] {
        ST_ISSUE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_STORE = 4'b0100,
        ST_RUN = 4'b1000
    } obc_state_t;

    obc_state_t state_ff;
    obc_state_t nxt_state;
    logic [1:0] idx_ff;
    logic [1:0] wait_ff;
    logic [7:0] opt_ff [4];
    logic [7:0] rd_data;
    logic [5:0] status;
    logic [7:0] ctrl_ff;
    logic aw_ff;
    logic w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Log2 of watchdog overflow cycles per code
    function automatic logic [4:0] ovf_log2(input logic [2:0] code);
        case (code)
            3'h0: ovf_log2 = 5'h06;
            3'h1: ovf_log2 = 5'h07;
            3'h2: ovf_log2 = 5'h08;
            3'h3: ovf_log2 = 5'h09;
            3'h4: ovf_log2 = 5'h0b;
            3'h5: ovf_log2 = 5'h0d;
            3'h6: ovf_log2 = 5'h0e;
            default: ovf_log2 = 5'h10;
        endcase
    endfunction

    // True when a frequency code is one of the nine legal values
    function automatic logic freq_ok(input logic [3:0] code);
        freq_ok = (code <= 4'h3) || (code >= 4'h9 && code <= 4'hd);
    endfunction

    // True for a listed detector encoding (three-level or twelve-level tables)
    function automatic logic detect_ok(input logic [7:0] b);
        logic [2:0] grp;
        logic [1:0] thr;
        logic [1:0] mode;
        grp = b[obc_pkg::B1_GRP_HI:obc_pkg::B1_GRP_LO];
        thr = b[obc_pkg::B1_THR_HI:obc_pkg::B1_THR_LO];
        mode = b[obc_pkg::B1_MODE_HI:obc_pkg::B1_MODE_LO];
        if (grp[2] && mode[0]) begin
            detect_ok = 1'b1;
        end else if (mode == obc_pkg::VD_INT_RST) begin
            detect_ok = (grp == 3'h1 || grp == 3'h2 || grp == 3'h3) && thr != 2'h3;
        end else if (mode == obc_pkg::VD_RST || mode == obc_pkg::VD_INT) begin
            detect_ok = !grp[2] && grp != 3'h0
                && !(grp == 3'h1 && thr == 2'h0 && 1'b0);
        end else begin
            detect_ok = 1'b0;
        end
    endfunction

    // Fetch sequence: issue read, wait for registered data, store
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_ISSUE: nxt_state = ST_WAIT;
            ST_WAIT: nxt_state = (wait_ff == 2'h2) ? ST_STORE : ST_WAIT;
            ST_STORE: nxt_state = (idx_ff == obc_pkg::OPT_COUNT) ? ST_RUN : ST_ISSUE;
            ST_RUN: nxt_state = ST_RUN;
            default: nxt_state = ST_ISSUE;
        endcase
    end

    obc_rom_port u_rom (
        .aclk(aclk),
        .aresetn(aresetn),
        .rd_en(state_ff == ST_ISSUE),
        .rd_idx(idx_ff),
        .nvm_addr(nvm_addr),
        .nvm_rd(nvm_rd),
        .nvm_data(nvm_data),
        .rd_data_ff(rd_data)
    );

    // Sequencer and raw byte capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_ISSUE;
            idx_ff <= 2'h0;
            wait_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= (state_ff == ST_WAIT) ? wait_ff + 2'h1 : 2'h0;
            if (state_ff == ST_STORE) begin
                opt_ff[idx_ff] <= rd_data;
                idx_ff <= idx_ff + 2'h1;
            end
        end
    end

    // Decode of the fetched bytes, taken once when the last byte lands
    wire [7:0] b0 = opt_ff[0];
    wire [7:0] b1 = opt_ff[1];
    wire [7:0] b2 = opt_ff[2];
    wire [7:0] b3 = (idx_ff == obc_pkg::OPT_COUNT) ? rd_data : opt_ff[3];
    wire load_done = (state_ff == ST_STORE) && (idx_ff == obc_pkg::OPT_COUNT);
    wire [1:0] win_raw = {b0[obc_pkg::B0_WIN_HI], b0[obc_pkg::B0_WIN_LO]};
    wire stby = b0[obc_pkg::B0_STBY];
    wire [1:0] win_eff = stby ? win_raw : obc_pkg::WIN_100;
    wire [1:0] vd_mode = b1[obc_pkg::B1_MODE_HI:obc_pkg::B1_MODE_LO];
    wire vd_off = b1[obc_pkg::B1_GRP_HI] & b1[obc_pkg::B1_MODE_LO];
    wire [1:0] flash_code = b2[obc_pkg::B2_FLASH_HI:obc_pkg::B2_FLASH_LO];
    wire [3:0] freq_code = b2[obc_pkg::B2_FREQ_HI:0];
    wire [1:0] dbg_code = {b3[obc_pkg::B3_DBG_EN], b3[obc_pkg::B3_NO_ERASE]};

    obc_pkg::obc_wdt_t wdt_dec;
    obc_pkg::obc_sys_t sys_dec;
    assign wdt_dec.run_enable = b0[obc_pkg::B0_RUN];
    assign wdt_dec.standby_run = stby;
    assign wdt_dec.interval_irq_en = b0[obc_pkg::B0_IRQ];
    assign wdt_dec.open_period = win_eff;
    assign wdt_dec.overflow_log2 = ovf_log2(b0[obc_pkg::B0_OVF_HI:obc_pkg::B0_OVF_LO]);
    assign sys_dec.detector_on = !vd_off;
    assign sys_dec.detector_mode = vd_off ? 2'h0 : vd_mode;
    assign sys_dec.level_group = b1[obc_pkg::B1_GRP_HI:obc_pkg::B1_GRP_LO];
    assign sys_dec.threshold_sel = b1[obc_pkg::B1_THR_HI:obc_pkg::B1_THR_LO];
    assign sys_dec.reset_pin_select = b1[obc_pkg::B1_PIN];
    assign sys_dec.flash_high_speed = flash_code[0];
    assign sys_dec.osc_freq_sel = freq_code;
    assign sys_dec.debug_enable = dbg_code[1];
    assign sys_dec.debug_no_erase = dbg_code == 2'h3;

    // Done flag and flags for prohibited codes, reported to software
    assign status[obc_pkg::ST_DONE] = cfg_valid_ff;
    assign status[obc_pkg::ST_BAD_WINDOW] = ({opt_ff[0][obc_pkg::B0_WIN_HI],
        opt_ff[0][obc_pkg::B0_WIN_LO]} == 2'h0) && cfg_valid_ff;
    assign status[obc_pkg::ST_BAD_DETECT] = !detect_ok(opt_ff[1]) && cfg_valid_ff;
    assign status[obc_pkg::ST_BAD_FLASH] = !opt_ff[2][obc_pkg::B2_FLASH_HI]
        && cfg_valid_ff;
    assign status[obc_pkg::ST_BAD_FREQ] = !freq_ok(opt_ff[2][obc_pkg::B2_FREQ_HI:0])
        && cfg_valid_ff;
    assign status[obc_pkg::ST_BAD_DEBUG] = ({opt_ff[3][obc_pkg::B3_DBG_EN],
        opt_ff[3][obc_pkg::B3_NO_ERASE]} == 2'h1) && cfg_valid_ff;

    // Decoded settings captured once and held until the next reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_valid_ff <= 1'b0;
            wdt_cfg_ff <= '0;
            sys_cfg_ff <= '0;
        end else if (load_done) begin
            cfg_valid_ff <= 1'b1;
            wdt_cfg_ff <= wdt_dec;
            sys_cfg_ff <= sys_dec;
        end
    end

    // AXI4-Lite write channel: address and data taken in either order
    wire wr_go = aw_ff && w_ff && !bvalid_ff;
    wire wr_ctrl = awaddr_ff[7:2] == obc_pkg::REG_CTRL[7:2];
    wire wr_ro = awaddr_ff[7:2] == obc_pkg::REG_WDT_CFG[7:2]
        || awaddr_ff[7:2] == obc_pkg::REG_VD_CFG[7:2]
        || awaddr_ff[7:2] == obc_pkg::REG_CLK_CFG[7:2]
        || awaddr_ff[7:2] == obc_pkg::REG_DBG_CFG[7:2]
        || awaddr_ff[7:2] == obc_pkg::REG_STATUS[7:2];
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= obc_pkg::RESP_OKAY;
            ctrl_ff <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (wr_ctrl || wr_ro) ? obc_pkg::RESP_OKAY : obc_pkg::RESP_SLVERR;
                if (wr_ctrl && wstrb_ff[0]) begin
                    ctrl_ff <= wdata_ff[7:0]; // Scratch byte only
                end
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel: first option byte, status and scratch
    wire [5:0] ra = s_axi_araddr[7:2];
    wire [31:0] rmux =
        (ra == obc_pkg::REG_WDT_CFG[7:2]) ? {24'h000000, opt_ff[0]} :
        (ra == obc_pkg::REG_STATUS[7:2]) ? {26'h0000000, status} :
        (ra == obc_pkg::REG_CTRL[7:2]) ? {24'h000000, ctrl_ff} : 32'h00000000;
    wire rhit = ra == obc_pkg::REG_WDT_CFG[7:2] || ra == obc_pkg::REG_STATUS[7:2]
        || ra == obc_pkg::REG_CTRL[7:2];
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= obc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rmux;
            rresp_ff <= rhit ? obc_pkg::RESP_OKAY : obc_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule

// ### hdl/obc_rom_port.sv
`timescale 1ns/1ps
// Registered read port onto the option byte area of non-volatile memory
module obc_rom_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rd_en,
    input wire logic [1:0] rd_idx,
    output logic [19:0] nvm_addr,
    output logic nvm_rd,
    input wire logic [7:0] nvm_data,
    output logic [7:0] rd_data_ff
);
    logic nvm_rd_ff;
    logic [19:0] nvm_addr_ff;
    logic pend_ff;

    assign nvm_addr = nvm_addr_ff;
    assign nvm_rd = nvm_rd_ff;

    // Read strobe lasts one cycle and the address holds until the next read; data captured the cycle after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nvm_rd_ff <= 1'b0;
            nvm_addr_ff <= 20'h00000;
            pend_ff <= 1'b0;
            rd_data_ff <= 8'h00;
        end else begin
            nvm_rd_ff <= rd_en;
            if (rd_en) begin
                nvm_addr_ff <= obc_pkg::OPT_BASE_ADDR + {18'h00000, rd_idx};
            end
            pend_ff <= nvm_rd_ff;
            if (pend_ff) begin
                rd_data_ff <= nvm_data;
            end
        end
    end
endmodule

// ### include/obc_pkg.sv
package obc_pkg;
    // Option byte addresses in non-volatile memory
    localparam logic [19:0] OPT_BASE_ADDR = 20'h000c0;
    localparam logic [1:0] OPT_COUNT = 2'h3;
    // AXI register byte offsets
    localparam logic [7:0] REG_WDT_CFG = 8'hc0;
    localparam logic [7:0] REG_VD_CFG = 8'hc1;
    localparam logic [7:0] REG_CLK_CFG = 8'hc2;
    localparam logic [7:0] REG_DBG_CFG = 8'hc3;
    localparam logic [7:0] REG_STATUS = 8'hd0;
    localparam logic [7:0] REG_CTRL = 8'hd4;
    // Status bit positions
    localparam int ST_DONE = 0;
    localparam int ST_BAD_WINDOW = 1;
    localparam int ST_BAD_DETECT = 2;
    localparam int ST_BAD_FLASH = 3;
    localparam int ST_BAD_FREQ = 4;
    localparam int ST_BAD_DEBUG = 5;
    // Byte 0 field positions
    localparam int B0_IRQ = 7;
    localparam int B0_WIN_HI = 6;
    localparam int B0_WIN_LO = 5;
    localparam int B0_RUN = 4;
    localparam int B0_OVF_HI = 3;
    localparam int B0_OVF_LO = 1;
    localparam int B0_STBY = 0;
    // Byte 1 field positions
    localparam int B1_GRP_HI = 7;
    localparam int B1_GRP_LO = 5;
    localparam int B1_PIN = 4;
    localparam int B1_THR_HI = 3;
    localparam int B1_THR_LO = 2;
    localparam int B1_MODE_HI = 1;
    localparam int B1_MODE_LO = 0;
    // Byte 2 and byte 3 field positions
    localparam int B2_FLASH_HI = 7;
    localparam int B2_FLASH_LO = 6;
    localparam int B2_FREQ_HI = 3;
    localparam int B3_DBG_EN = 7;
    localparam int B3_NO_ERASE = 0;
    // Window open period codes
    localparam logic [1:0] WIN_50 = 2'h1;
    localparam logic [1:0] WIN_75 = 2'h2;
    localparam logic [1:0] WIN_100 = 2'h3;
    // Detector modes, as encoded by the two mode bits
    localparam logic [1:0] VD_INT_RST = 2'h2;
    localparam logic [1:0] VD_RST = 2'h3;
    localparam logic [1:0] VD_INT = 2'h1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded watchdog settings
    typedef struct packed {
        logic run_enable;
        logic standby_run;
        logic interval_irq_en;
        logic [1:0] open_period;
        logic [4:0] overflow_log2;
    } obc_wdt_t;

    // Decoded detector, pin, clock and debug settings
    typedef struct packed {
        logic detector_on;
        logic [1:0] detector_mode;
        logic [2:0] level_group;
        logic [1:0] threshold_sel;
        logic reset_pin_select;
        logic flash_high_speed;
        logic [3:0] osc_freq_sel;
        logic debug_enable;
        logic debug_no_erase;
    } obc_sys_t;
endpackage

// ### sim/obc_nvm_model.sv
`timescale 1ns/1ps
// Option byte area of the non-volatile memory, registered read
module obc_nvm_model (
    input wire logic aclk,
    input wire logic [19:0] nvm_addr,
    input wire logic nvm_rd,
    input wire logic [31:0] bytes_in,
    output logic [7:0] nvm_data
);
    logic [7:0] data_ff;
    logic [1:0] age_ff = 2'h3;

    // All four bytes always present; byte picked by address offset
    always_ff @(posedge aclk) begin
        if (nvm_rd) begin
            data_ff <= bytes_in[8*nvm_addr[1:0] +: 8];
            age_ff <= 2'h0;
        end else if (age_ff != 2'h3) begin
            age_ff <= age_ff + 2'h1;
        end
    end

    // Data valid only while held; afterwards the bus shows garbage
    assign nvm_data = (age_ff < 2'h2) ? data_ff : ~data_ff;
endmodule

// ### sim/obc_props.sv
`timescale 1ns/1ps
// Port-level checks on the option byte loader
module obc_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [19:0] nvm_addr,
    input wire logic nvm_rd,
    input wire obc_pkg::obc_wdt_t wdt_cfg_ff,
    input wire obc_pkg::obc_sys_t sys_cfg_ff,
    input wire logic cfg_valid_ff
);
    // All checks share the one clock and its reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Memory fetch strobe and address window
    a_rd_strobe: assert property (nvm_rd |=> !nvm_rd)
        else $error("memory read strobe wider than one cycle");
    a_rd_range: assert property (nvm_rd |-> nvm_addr >= 20'h000c0 && nvm_addr <= 20'h000c3)
        else $error("memory read outside the option area");
    // Load completes soon after release and then holds
    a_load_time: assert property ($rose(aresetn) |-> ##[1:40] cfg_valid_ff)
        else $error("settings not loaded in time");
    a_valid_holds: assert property (cfg_valid_ff |=> cfg_valid_ff)
        else $error("valid flag dropped without reset");
    a_cfg_frozen: assert property (cfg_valid_ff && $past(cfg_valid_ff) |->
        $stable(wdt_cfg_ff) && $stable(sys_cfg_ff))
        else $error("settings changed after load");
    // Decoded field relations
    a_window_forced: assert property (cfg_valid_ff && !wdt_cfg_ff.standby_run |->
        wdt_cfg_ff.open_period == 2'h3)
        else $error("window not full with standby stop");
    a_overflow_set: assert property (cfg_valid_ff |-> wdt_cfg_ff.overflow_log2 inside
        {5'h06, 5'h07, 5'h08, 5'h09, 5'h0b, 5'h0d, 5'h0e, 5'h10})
        else $error("overflow exponent out of set");
    a_detect_off: assert property (cfg_valid_ff && !sys_cfg_ff.detector_on |->
        sys_cfg_ff.detector_mode == 2'h0)
        else $error("detector mode shown while off");
    a_debug_pair: assert property (cfg_valid_ff && sys_cfg_ff.debug_no_erase |->
        sys_cfg_ff.debug_enable)
        else $error("no-erase without debug enabled");

    // Main scenarios reached
    c_loaded: cover property ($rose(cfg_valid_ff));
    c_det_off: cover property (cfg_valid_ff && !sys_cfg_ff.detector_on);
    c_standby: cover property (cfg_valid_ff && wdt_cfg_ff.standby_run);
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
// Compare one value pair and count the outcome
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [19:0] nvm_addr;
    logic nvm_rd;
    logic [7:0] nvm_data;
    obc_pkg::obc_wdt_t wdt_cfg_ff;
    obc_pkg::obc_sys_t sys_cfg_ff;
    logic cfg_valid_ff;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] opt_bytes = 32'h0;
    logic [31:0] rng = 32'hb872ac67;
    int miscompares = 0;
    int tests_run = 0;
    localparam logic [39:0] OVF_TAB = {5'h10, 5'h0e, 5'h0d, 5'h0b, 5'h09, 5'h08, 5'h07, 5'h06};
    localparam logic [35:0] FREQ_TAB = {4'hd, 4'hc, 4'h3, 4'hb, 4'h2, 4'ha, 4'h1, 4'h9, 4'h0};

    obc_config_loader uut (.aclk, .aresetn, .nvm_addr, .nvm_rd, .nvm_data, .wdt_cfg_ff,
        .sys_cfg_ff, .cfg_valid_ff, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    obc_nvm_model nvm (.aclk, .nvm_addr, .nvm_rd, .bytes_in(opt_bytes), .nvm_data);

    // 100 MHz clock
    always #5 aclk = ~aclk;

    // Repeatable random source
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Expected watchdog settings from the first byte
    function automatic obc_pkg::obc_wdt_t exp_wdt(input logic [7:0] b);
        return {b[4], b[0], b[7], b[0] ? b[6:5] : 2'h3, OVF_TAB[5*b[3:1] +: 5]};
    endfunction

    // Expected detector, pin, clock and debug settings
    function automatic obc_pkg::obc_sys_t exp_sys(input logic [7:0] b1, b2, b3);
        logic on;
        on = !(b1[7] && b1[0]);
        return {on, on ? b1[1:0] : 2'h0, b1[7:5], b1[3:2], b1[4], b2[6], b2[3:0], b3[7],
            b3[7] & b3[0]};
    endfunction

    // Counts, verdict and end of run
    task close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // A wait that ran out
    task hang();
        miscompares++;
        close_out();
    endtask

    // Register write: address and data offered together
    task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ah, wh, bh;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) hang();
    endtask

    // Register read
    task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ah, dh;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            dh = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (dh) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) hang();
    endtask

    // Main sequence: program, reset, load, compare, disturb memory
    initial begin
        logic [7:0] b0, b1, b2, b3;
        logic [2:0] grp;
        logic [1:0] dc, rs;
        logic [31:0] r, d;
        int n;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        for (int i = 0; i < 12; i++) begin
            @(posedge aclk);
            r = rnd();
            b0 = r[7:0];
            if (b0[6:5] == 2'h0) b0[6:5] = 2'h1;
            grp = 3'h1 + 3'(r[9:8] % 2'h3);
            case (i % 4)
                0: b1 = {grp, r[12], r[11:10] == 2'h3 ? 2'h2 : r[11:10], 2'h2};
                1: b1 = {grp, r[12], r[11:10], 2'h3};
                2: b1 = {grp, r[12], r[11:10], 2'h1};
                default: b1 = {1'b1, r[14:13], r[12], r[11:10], r[15], 1'b1};
            endcase
            b2 = {1'b1, i[0], 2'h2, FREQ_TAB[4*(i%9) +: 4]};
            dc = (i % 3 == 0) ? 2'h0 : {1'b1, i % 3 == 2};
            b3 = {dc[1], 6'h02, dc[0]};
            opt_bytes <= {b3, b2, b1, b0};
            aresetn <= 1'b0;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            @(negedge aclk);
            `CHK(cfg_valid_ff, 1'b0)
            for (n = 0; n < 100 && cfg_valid_ff !== 1'b1; n++) @(negedge aclk);
            if (n == 100) hang();
            `CHK(wdt_cfg_ff, exp_wdt(b0))
            `CHK(sys_cfg_ff, exp_sys(b1, b2, b3))
            axr(obc_pkg::REG_WDT_CFG, d, rs);
            `CHK(d, {24'h0, b0})
            axr(obc_pkg::REG_STATUS, d, rs);
            `CHK(d[5:0], 6'h01)
            opt_bytes <= ~opt_bytes;
            repeat (8) @(posedge aclk);
            @(negedge aclk);
            `CHK({wdt_cfg_ff, sys_cfg_ff}, {exp_wdt(b0), exp_sys(b1, b2, b3)})
        end
        // Unmapped, read-only, status and scratch accesses
        axr(8'h80, d, rs);
        `CHK(rs, obc_pkg::RESP_SLVERR)
        axw(obc_pkg::REG_WDT_CFG, rnd(), rs);
        `CHK(rs, obc_pkg::RESP_OKAY)
        axr(obc_pkg::REG_WDT_CFG, d, rs);
        `CHK(d, {24'h0, b0})
        axr(obc_pkg::REG_STATUS, d, rs);
        `CHK(d[5:0], 6'h01)
        r = rnd();
        axw(obc_pkg::REG_CTRL, {24'h0, r[7:0]}, rs);
        axr(obc_pkg::REG_CTRL, d, rs);
        `CHK(d, {24'h0, r[7:0]})
        // One prohibited code per checked field at once: all five fault flags must show
        opt_bytes <= 32'h053e8201;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (n = 0; n < 100 && cfg_valid_ff !== 1'b1; n++) @(negedge aclk);
        if (n == 100) hang();
        axr(obc_pkg::REG_STATUS, d, rs);
        `CHK(d[5:0], 6'h3f)
        close_out();
    end
endmodule

bind obc_config_loader obc_props u_props (.aclk, .aresetn, .nvm_addr, .nvm_rd, .wdt_cfg_ff,
    .sys_cfg_ff, .cfg_valid_ff);
